// [rtl/daq_regs_pkg.sv]
// Constants for the acquisition card control, interrupt and port registers
package daq_regs_pkg;
  localparam logic [11:0] OFS_INIT_STATUS = 12'h200;
  localparam logic [11:0] OFS_IRQ_FLAGS   = 12'h204;
  localparam logic [11:0] OFS_PORT_DIR    = 12'h210;
  localparam logic [11:0] OFS_PORT_DATA   = 12'h214;
  localparam logic [11:0] OFS_FIFO_READ   = 12'h218;
  localparam logic [11:0] OFS_FIFO_FLAGS  = 12'h21C;
  localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h224;
  // Initialize register bit positions
  localparam int INIT_AI_MODE   = 0;
  localparam int INIT_AI_FIFO   = 1;
  localparam int INIT_AI_OVF    = 2;
  localparam int INIT_IRQ_CLR   = 3;
  localparam int INIT_DI_FIFO   = 6;
  localparam int INIT_DO_FIFO   = 7;
  localparam int INIT_AO0_FIFO  = 8;
  localparam int INIT_WIDTH     = 9;
  // Status field positions, interrupt and port counts
  localparam int HWS_ID_LSB     = 0;
  localparam int HWS_DIR_LSB    = 8;
  localparam int NUM_IRQ        = 12;
  localparam int NUM_PORTS      = 4;
  // Direction register fields
  localparam int DIR_OUT_LSB    = 0;
  localparam int DIR_FILT_LSB   = 4;
  localparam int DIR_DICLK_LSB  = 8;
  localparam int DIR_DOCLK_LSB  = 11;
  localparam int DIR_PATTERN    = 14;
  localparam int DIR_WIDTH      = 15;
  localparam logic [2:0] DICLK_ON = 3'h4;
  localparam logic [2:0] DOCLK_ON = 3'h5;
  // Input FIFO flag positions
  localparam int FF_EMPTY       = 16;
  localparam int FF_FULL        = 17;
  localparam int FF_HALF        = 18;
  localparam int FF_OVF         = 21;
  // Reset value and glitch filter length
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int FILTER_CYCLES  = 4;
endpackage

// [rtl/daq_regs.sv]
// Control, interrupt and digital port register bank of the acquisition card
module daq_regs
  import daq_regs_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int AW         = $clog2(FIFO_DEPTH)
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  // Local bus, one word per access
  input  wire logic        bus_sel,
  input  wire logic        bus_wr,
  input  wire logic [11:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  output logic [31:0]      bus_rdata,
  output logic             bus_ack,
  // Board identity switch, four bits
  input  wire logic [3:0]  board_id_switch,
  // Event pulses from the acquisition logic
  input  wire logic [11:0] irq_event,
  output logic             irq_req,
  // Port pins, input/output/enable per bit
  input  wire logic [31:0] port_in,
  output logic [31:0]      port_out,
  output logic [31:0]      port_oe,
  // Port A pattern data
  input  wire logic [7:0]  pattern_data,
  // Control pulses and clock enables to the acquisition logic
  output logic             ai_mode_reset,
  output logic             ai_fifo_clear,
  output logic             ai_ovf_clear,
  output logic             do_fifo_reset,
  output logic             ao0_fifo_reset,
  output logic             di_clk_enable,
  output logic             do_clk_enable,
  // Sampling strobe for the port C input FIFO
  input  wire logic        di_sample
);

  typedef struct packed {
    logic [INIT_WIDTH-1:0] init;
    logic [NUM_IRQ-1:0]    flag_wr;
    logic [NUM_IRQ-1:0]    flag;
    logic [NUM_IRQ-1:0]    enable;
    logic [DIR_WIDTH-1:0]  dir;
    logic [31:0]           out;
    logic [31:0]           s1;
    logic [31:0]           s2;
    logic [31:0]           s3;
    logic [31:0]           filt;
    logic [NUM_PORTS-1:0][2:0] fcnt;
    logic                  irq_hold;
    logic [AW-1:0]         wp;
    logic [AW-1:0]         rp;
    logic [AW:0]           cnt;
    logic                  ovf;
    logic [31:0]           rdata;
    logic                  ack;
    logic [4:0]            pulse;
    logic [3:0]            id1;
    logic [3:0]            id2;
    logic [3:0]            id3;
    logic [3:0]            id;
  } state_s;

  state_s q, d;
  logic [7:0] fifo_mem [FIFO_DEPTH];

  // Decoded falling edge of a written one: the one-zero sequence
  function automatic logic fell(input logic old_b, input logic new_b);
    return old_b & ~new_b;
  endfunction

  logic wr_hit, rd_hit, fifo_push, fifo_pop;
  logic [31:0] port_view;
  logic [INIT_WIDTH-1:0] init_fall;

  always_comb begin
    wr_hit = bus_sel & bus_wr;
    rd_hit = bus_sel & ~bus_wr;
    init_fall = q.init & ~bus_wdata[INIT_WIDTH-1:0]
                & {INIT_WIDTH{wr_hit && bus_addr == OFS_INIT_STATUS}};
    fifo_pop = rd_hit && bus_addr == OFS_FIFO_READ && q.cnt != '0;
    fifo_push = di_sample && q.dir[DIR_DICLK_LSB +: 3] == DICLK_ON
                && q.cnt != (AW+1)'(FIFO_DEPTH);
    // Input lanes read pins, output lanes read back latch
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_view[p*8 +: 8] = q.dir[DIR_OUT_LSB+p] ? q.out[p*8 +: 8]
                                                 : q.filt[p*8 +: 8];
    end
  end

  // Next-state logic for the whole bank
  always_comb begin
    d = q;
    d.ack = bus_sel;
    d.s1 = port_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Switch synchroniser; a new setting counts once two stages agree
    d.id1 = board_id_switch;
    d.id2 = q.id1;
    d.id3 = q.id2;
    if (q.id2 == q.id3)
      d.id = q.id3;
    d.pulse = {init_fall[INIT_AO0_FIFO], init_fall[INIT_DO_FIFO],
               init_fall[INIT_AI_OVF], init_fall[INIT_AI_FIFO],
               init_fall[INIT_AI_MODE]};
    // Glitch filter: change accepted after steady count, or once two stages agree when the port filter is off
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (q.s2[p*8+b] == q.s3[p*8+b] && !q.dir[DIR_FILT_LSB+p])
          d.filt[p*8+b] = q.s3[p*8+b];
      end
      if (q.dir[DIR_FILT_LSB+p]) begin
        if (q.s2[p*8 +: 8] != q.s3[p*8 +: 8]
            || q.s3[p*8 +: 8] == q.filt[p*8 +: 8])
          d.fcnt[p] = '0;
        else if (q.fcnt[p] == 3'(FILTER_CYCLES - 1)) begin
          d.filt[p*8 +: 8] = q.s3[p*8 +: 8];
          d.fcnt[p] = '0;
        end else
          d.fcnt[p] = q.fcnt[p] + 3'h1;
      end
    end
    // Register writes
    if (wr_hit) begin
      case (bus_addr)
        OFS_INIT_STATUS: d.init = bus_wdata[INIT_WIDTH-1:0];
        OFS_IRQ_FLAGS: d.flag_wr = bus_wdata[NUM_IRQ-1:0];
        OFS_PORT_DIR: d.dir = bus_wdata[DIR_WIDTH-1:0];
        OFS_PORT_DATA: d.out = bus_wdata;
        OFS_IRQ_ENABLE: d.enable = bus_wdata[NUM_IRQ-1:0];
        default: ;
      endcase
    end
    // Flags: clear on one-zero, a same-cycle event wins
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (wr_hit && bus_addr == OFS_IRQ_FLAGS
          && fell(q.flag_wr[i], bus_wdata[i]))
        d.flag[i] = 1'b0;
      if (irq_event[i])
        d.flag[i] = 1'b1;
    end
    // Host clear holds request low until a fresh event
    if (init_fall[INIT_IRQ_CLR])
      d.irq_hold = 1'b1;
    else if (|irq_event)
      d.irq_hold = 1'b0;
    // Port C input FIFO
    if (init_fall[INIT_DI_FIFO]) begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
      d.ovf = 1'b0;
    end else begin
      if (fifo_push)
        d.wp = q.wp + AW'(1);
      if (fifo_pop)
        d.rp = q.rp + AW'(1);
      d.cnt = q.cnt + (AW+1)'(fifo_push) - (AW+1)'(fifo_pop);
      if (di_sample && !fifo_push
          && q.dir[DIR_DICLK_LSB +: 3] == DICLK_ON)
        d.ovf = 1'b1;
    end
    // Read data registered for the answer cycle
    d.rdata = RST_WORD;
    if (rd_hit) begin
      case (bus_addr)
        OFS_INIT_STATUS: begin
          d.rdata[HWS_ID_LSB +: 4] = q.id;
          d.rdata[HWS_DIR_LSB +: NUM_PORTS] = q.dir[NUM_PORTS-1:0];
        end
        OFS_IRQ_FLAGS: d.rdata[NUM_IRQ-1:0] = q.flag;
        OFS_PORT_DIR: d.rdata[DIR_WIDTH-1:0] = q.dir;
        OFS_PORT_DATA: d.rdata = port_view;
        OFS_FIFO_READ: d.rdata[7:0] = fifo_mem[q.rp];
        OFS_FIFO_FLAGS: begin
          d.rdata[FF_EMPTY] = q.cnt == '0;
          d.rdata[FF_FULL] = q.cnt == (AW+1)'(FIFO_DEPTH);
          d.rdata[FF_HALF] = q.cnt >= (AW+1)'(FIFO_DEPTH / 2);
          d.rdata[FF_OVF] = q.ovf;
        end
        OFS_IRQ_ENABLE: d.rdata[NUM_IRQ-1:0] = q.enable;
        default: d.rdata = RST_WORD;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  // FIFO storage has no reset; pointers guard stale words
  always_ff @(posedge clk) begin
    if (fifo_push)
      fifo_mem[q.wp] <= q.filt[23:16];
  end

  // Outputs
  always_comb begin
    bus_rdata = q.rdata;
    bus_ack = q.ack;
    irq_req = |(q.flag & q.enable) & ~q.irq_hold;
    ai_mode_reset = q.pulse[0];
    ai_fifo_clear = q.pulse[1];
    ai_ovf_clear = q.pulse[2];
    do_fifo_reset = q.pulse[3];
    ao0_fifo_reset = q.pulse[4];
    di_clk_enable = q.dir[DIR_DICLK_LSB +: 3] == DICLK_ON;
    do_clk_enable = q.dir[DIR_DOCLK_LSB +: 3] == DOCLK_ON;
    port_out = q.out;
    if (q.dir[DIR_PATTERN])
      port_out[7:0] = pattern_data;
    for (int p = 0; p < NUM_PORTS; p++)
      port_oe[p*8 +: 8] = {8{q.dir[DIR_OUT_LSB+p]}};
  end

endmodule // daq_regs

// [test/daq_regs_assertions.sv]
// Bus, control pulse and interrupt checks for the register bank
module daq_regs_checker
  import daq_regs_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        bus_sel,
  input wire logic        bus_wr,
  input wire logic [11:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic        bus_ack,
  input wire logic [11:0] irq_event,
  input wire logic        irq_req,
  input wire logic [31:0] port_oe,
  input wire logic        ai_mode_reset,
  input wire logic        ai_fifo_clear,
  input wire logic        di_clk_enable,
  input wire logic        do_clk_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Zero written to the FIFO clear bit; the pulse may lag by one stage
  logic clr_low;
  assign clr_low = bus_sel && bus_wr && bus_addr == OFS_INIT_STATUS
    && !bus_wdata[INIT_AI_FIFO];
  sequence wr_dir;
    bus_sel && bus_wr && bus_addr == OFS_PORT_DIR;
  endsequence
  ack_after_sel_a: assert property (bus_sel |=> bus_ack)
    else $error("no acknowledge after access");
  oe_from_dir_a: assert property (
    wr_dir ##0 bus_wdata[0] |-> ##[1:2] port_oe[7:0] == 8'hFF)
    else $error("port A not driving");
  diclk_on_a: assert property (
    wr_dir ##0 bus_wdata[10:8] == DICLK_ON |-> ##[1:2] di_clk_enable)
    else $error("input clock not enabled");
  doclk_off_a: assert property (
    wr_dir ##0 bus_wdata[13:11] != DOCLK_ON |-> ##[1:2] !do_clk_enable)
    else $error("output clock enabled wrongly");
  pulse_single_a: assert property (ai_mode_reset |=> !ai_mode_reset)
    else $error("mode reset longer than one cycle");
  pulse_cause_a: assert property (
    $rose(ai_fifo_clear) |-> $past(clr_low) || $past(clr_low, 2))
    else $error("fifo clear without zero write");
  irq_cause_a: assert property (
    $rose(irq_req) |-> $past(|irq_event || (bus_sel && bus_wr)))
    else $error("interrupt raised without cause");
  status_dir_a: assert property (
    bus_sel && !bus_wr && bus_addr == OFS_INIT_STATUS
    |=> bus_rdata[11:8] ==
        {port_oe[24], port_oe[16], port_oe[8], port_oe[0]})
    else $error("status directions disagree");
endmodule // daq_regs_checker

bind daq_regs daq_regs_checker u_chk (.clk(clk), .nrst(nrst),
  .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
  .irq_event(irq_event), .irq_req(irq_req), .port_oe(port_oe),
  .ai_mode_reset(ai_mode_reset), .ai_fifo_clear(ai_fifo_clear),
  .di_clk_enable(di_clk_enable), .do_clk_enable(do_clk_enable));

// [test/pin_board_model.sv]
// Board-side pin model: each pin follows the card or the outside load
module pin_board_model (
  input  wire logic [31:0] port_out,
  input  wire logic [31:0] port_oe,
  input  wire logic [31:0] ext_level,
  output logic [31:0]      pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Undriven pins show the load, never a stale card value
  assign pin_level = (port_out & port_oe) | (ext_level & ~port_oe);
endmodule // pin_board_model

// [test/daq_regs_tb_top.sv]
// Self-checking bench for the control, interrupt and port register bank
module daq_regs_tb_top
  import daq_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, nrst = 0, bus_sel = 0, bus_wr = 0, di_sample = 0;
  logic [11:0] bus_addr = '0, irq_event = '0;
  logic [31:0] bus_wdata = '0, bus_rdata, port_out, port_oe, pins, rd;
  logic        bus_ack, irq_req, ai_mode_reset, ai_fifo_clear, ai_ovf_clear;
  logic        do_fifo_reset, ao0_fifo_reset, di_clk_enable, do_clk_enable;
  logic [4:0]  pulse_seen = '0;
  int          mismatches = 0, checked = 0;
  int          bitpos[5] = '{INIT_AI_MODE, INIT_AI_FIFO, INIT_AI_OVF,
                             INIT_DO_FIFO, INIT_AO0_FIFO};
  always #2 clk = ~clk;
  daq_regs u_dut (.clk(clk), .nrst(nrst), .bus_sel(bus_sel),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .board_id_switch(4'hA),
    .irq_event(irq_event), .irq_req(irq_req), .port_in(pins),
    .port_out(port_out), .port_oe(port_oe), .pattern_data(8'h5A),
    .ai_mode_reset(ai_mode_reset), .ai_fifo_clear(ai_fifo_clear),
    .ai_ovf_clear(ai_ovf_clear), .do_fifo_reset(do_fifo_reset),
    .ao0_fifo_reset(ao0_fifo_reset), .di_clk_enable(di_clk_enable),
    .do_clk_enable(do_clk_enable), .di_sample(di_sample));
  pin_board_model u_pins (.port_out(port_out), .port_oe(port_oe),
    .ext_level(32'hDDCC_BBAA), .pin_level(pins));
  // Sticky record of every control pulse seen
  always @(posedge clk) pulse_seen <= pulse_seen | {ao0_fifo_reset,
    do_fifo_reset, ai_ovf_clear, ai_fifo_clear, ai_mode_reset};
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One word access: request for one edge, answer read just after it, then one idle edge
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    bus_sel = 1;
    bus_wr = w;
    bus_addr = a;
    bus_wdata = d;
    tick(1);
    rd = bus_rdata;
    chk({31'h0, bus_ack}, 32'h1);
    bus_sel = 0;
    tick(1);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    acc(0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    tick(3);
    nrst = 1;
    tick(6);
    rchk(OFS_INIT_STATUS, 32'h0000_000A);
    acc(1, OFS_PORT_DIR, 32'h0);
    acc(1, OFS_PORT_DIR, 32'h0000_2C03);
    rchk(OFS_PORT_DIR, 32'h0000_2C03);
    rchk(OFS_INIT_STATUS, 32'h0000_030A);
    chk({30'h0, di_clk_enable, do_clk_enable}, 32'h3);
    chk(port_oe, 32'h0000_FFFF);
    acc(1, OFS_PORT_DATA, 32'h4433_2211);
    tick(4);
    chk(port_out & port_oe, 32'h0000_2211);
    rchk(OFS_PORT_DATA, 32'hDDCC_2211);
    di_sample = 1;
    tick(1);
    di_sample = 0;
    tick(2);
    rchk(OFS_FIFO_READ, 32'h0000_00CC);
    rchk(OFS_FIFO_FLAGS, 32'h0001_0000);
    rchk(12'h208, 32'h0);
    // Each source: latch while masked, then enable, then clear
    for (int i = 0; i < NUM_IRQ; i++) begin
      acc(1, OFS_IRQ_ENABLE, 32'h0);
      irq_event[i] = 1;
      tick(1);
      irq_event = '0;
      tick(1);
      chk({31'h0, irq_req}, 32'h0);
      rchk(OFS_IRQ_FLAGS, 32'h1 << i);
      acc(1, OFS_IRQ_ENABLE, 32'h1 << i);
      chk({31'h0, irq_req}, 32'h1);
      acc(1, OFS_IRQ_FLAGS, 32'h1 << i);
      acc(1, OFS_IRQ_FLAGS, 32'h0);
      chk({31'h0, irq_req}, 32'h0);
      rchk(OFS_IRQ_FLAGS, 32'h0);
    end
    irq_event = 12'h800;
    tick(1);
    irq_event = '0;
    tick(1);
    chk({31'h0, irq_req}, 32'h1);
    acc(1, OFS_INIT_STATUS, 32'h1 << INIT_IRQ_CLR);
    acc(1, OFS_INIT_STATUS, 32'h0);
    chk({31'h0, irq_req}, 32'h0);
    // Control pulses fire on the zero write only
    for (int k = 0; k < 5; k++) begin
      acc(1, OFS_INIT_STATUS, 32'h1 << bitpos[k]);
      tick(2);
      chk({27'h0, pulse_seen}, (32'h1 << k) - 1);
      acc(1, OFS_INIT_STATUS, 32'h0);
      tick(2);
      chk({27'h0, pulse_seen}, (32'h2 << k) - 1);
    end
    acc(1, OFS_PORT_DIR, 32'h0000_4001);
    tick(3);
    chk({24'h0, port_out[7:0]}, 32'h0000_005A);
    wrap_up();
  end
endmodule // daq_regs_tb_top
